// [src/stepper_ctrl_pkg.sv]
// Shared constants, field layout and carrier types of the stepper control bank
package stepper_ctrl_pkg;

  // Clock rate
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int CYC_PER_MS = CLK_FREQ_HZ / 1000;

  // Register addresses
  localparam logic [4:0] ADDR_STEP_CTRL = 5'h05;
  localparam logic [4:0] ADDR_FAULT_CTRL = 5'h06;
  localparam logic [4:0] ADDR_STALL_CTRL = 5'h07;

  // Reset values
  localparam logic [7:0] STEP_CTRL_RST = 8'h00;
  localparam logic [7:0] FAULT_CTRL_RST = 8'h30;
  localparam logic [7:0] STALL_CTRL_RST = 8'h08;

  // Step, direction and resolution fields
  localparam int DIR_BIT = 7;
  localparam int STEP_BIT = 6;
  localparam int DIR_SRC_BIT = 5;
  localparam int STEP_SRC_BIT = 4;
  localparam int RES_MSB = 3;
  localparam int RES_LSB = 0;

  // Fault and lock fields
  localparam int FLT_CLR_BIT = 7;
  localparam int LOCK_MSB = 6;
  localparam int LOCK_LSB = 4;
  localparam int OL_EN_BIT = 3;
  localparam int OCP_SEL_BIT = 2;
  localparam int OTSD_SEL_BIT = 1;
  localparam int THERMAL_WARNING_REPORT_BIT = 0;
  localparam logic [2:0] LOCK_CLOSE = 3'h6;
  localparam logic [2:0] LOCK_OPEN = 3'h3;

  // Stall and open-load fields
  localparam int STL_RSVD_MSB = 7;
  localparam int STL_RSVD_LSB = 6;
  localparam int STALL_LEARN_REQUEST_BIT = 5;
  localparam int STL_EN_BIT = 4;
  localparam int STALL_REPORT_ENABLE_BIT = 3;
  localparam int OPEN_LOAD_TIME_SELECT_MSB = 2;
  localparam int OPEN_LOAD_TIME_SELECT_LSB = 1;
  localparam int BLANK_BIT = 0;

  // Resolution codes
  localparam logic [3:0] RES_FULL_71 = 4'h1;
  localparam logic [3:0] RES_HALF_NC = 4'h2;
  localparam logic [3:0] RES_OFFSET = 4'h2;
  localparam logic [3:0] RES_LAST = 4'ha;

  // Serial frame layout
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam int FRAME_READ_BIT = 14;
  localparam int FRAME_ADDR_MSB = 13;
  localparam int FRAME_ADDR_LSB = 9;
  localparam logic [4:0] RD_LOAD_BIT = 5'h08;
  localparam logic [1:0] STATUS_HEAD = 2'h3;

  // Longest open-load detection times
  localparam int OL_TIME0_MS = 200;
  localparam int OL_TIME1_MS = 125;
  localparam int OL_TIME2_MS = 75;
  localparam int OL_TIME3_MS = 3;
  localparam int OL_TIME0_CYC = OL_TIME0_MS * CYC_PER_MS;
  localparam int OL_TIME1_CYC = OL_TIME1_MS * CYC_PER_MS;
  localparam int OL_TIME2_CYC = OL_TIME2_MS * CYC_PER_MS;
  localparam int OL_TIME3_CYC = OL_TIME3_MS * CYC_PER_MS;
  localparam int OL_CNT_W = 25;

  typedef struct packed {
    logic write;
    logic [4:0] addr;
    logic [7:0] data;
  } spi_req_t;

  typedef struct packed {
    logic [3:0] ustepLog2;
    logic fullStepReduced;
    logic nonCircularHalf;
    logic openLoadEnable;
    logic overcurrentResponseSelect;
    logic thermalShutdownResponseSelect;
    logic stallDetectEnable;
    logic stallLearnRequest;
    logic stallReportEnable;
    logic [1:0] openLoadTimeSelect;
    logic slewBasedBlankingSelect;
  } drv_cfg_t;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_SHIFT = 2'b01,
    LINK_DONE = 2'b11
  } link_state_t;

endpackage : stepper_ctrl_pkg

// [src/spi_frame_link.sv]
// Serial frame receiver and reply shifter, sampled on the reference clock
`timescale 1ns/10ps
module spi_frame_link (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdi,
  input wire logic [7:0] statusByte,
  input wire logic [7:0] rdData,
  output logic [4:0] rdAddr,
  output logic sdo,
  output logic sdoEn,
  output stepper_ctrl_pkg::spi_req_t req,
  output logic reqValid
);
  import stepper_ctrl_pkg::*;

  logic sclkMeta, sclkSync, sclkDly, csMeta, csSync, sdiMeta, sdiSync;
  logic sclkRise, sclkFall;
  link_state_t state;
  logic [4:0] bitCnt;
  logic [15:0] shiftIn;
  logic [7:0] statusLatch, rdLatch;

  // Two-flop synchronisers; edge detect looks only at the second stage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclkMeta <= 1'b0;
      sclkSync <= 1'b0;
      sclkDly <= 1'b0;
      csMeta <= 1'b1;
      csSync <= 1'b1;
      sdiMeta <= 1'b0;
      sdiSync <= 1'b0;
    end else begin
      sclkMeta <= sclk;
      sclkSync <= sclkMeta;
      sclkDly <= sclkSync;
      csMeta <= csN;
      csSync <= csMeta;
      sdiMeta <= sdi;
      sdiSync <= sdiMeta;
    end
  end

  assign sclkRise = sclkSync & ~sclkDly;
  assign sclkFall = ~sclkSync & sclkDly;

  // Frame sequencing: a frame counts only with exactly sixteen bits
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= LINK_IDLE;
      bitCnt <= 5'h00;
      shiftIn <= 16'h0000;
      statusLatch <= 8'h00;
    end else begin
      case (state)
        LINK_IDLE: begin
          if (!csSync) begin
            state <= LINK_SHIFT;
            bitCnt <= 5'h00;
            statusLatch <= statusByte;
          end
        end
        LINK_SHIFT: begin
          if (csSync) begin
            state <= LINK_DONE;
          end else if (sclkFall) begin
            shiftIn <= {shiftIn[14:0], sdiSync};
            if (bitCnt != 5'h1f) begin
              bitCnt <= bitCnt + 5'h01;
            end
          end
        end
        LINK_DONE: state <= LINK_IDLE;
        default: state <= LINK_IDLE;
      endcase
    end
  end

  // Reply bits launch on rising edges; the data byte is caught at bit eight
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sdo <= 1'b0;
      rdLatch <= 8'h00;
    end else if (state == LINK_SHIFT && sclkRise) begin
      if (bitCnt < RD_LOAD_BIT) begin
        sdo <= statusLatch[~bitCnt[2:0]];
      end else if (bitCnt == RD_LOAD_BIT) begin
        sdo <= rdData[7];
        rdLatch <= rdData;
      end else begin
        sdo <= rdLatch[~bitCnt[2:0]];
      end
    end
  end

  assign rdAddr = shiftIn[5:1];
  assign sdoEn = (state == LINK_SHIFT);
  assign reqValid = (state == LINK_DONE) && (bitCnt == FRAME_BITS);
  assign req.write = ~shiftIn[FRAME_READ_BIT];
  assign req.addr = shiftIn[FRAME_ADDR_MSB:FRAME_ADDR_LSB];
  assign req.data = shiftIn[7:0];

endmodule : spi_frame_link

// [src/open_load_timer.sv]
// Open-load qualification timer with four selectable windows
`timescale 1ns/10ps
module open_load_timer #(
  parameter int unsigned CYC0 = 20_000_000,
  parameter int unsigned CYC1 = 12_500_000,
  parameter int unsigned CYC2 = 7_500_000,
  parameter int unsigned CYC3 = 300_000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [1:0] timeSelect,
  input wire logic condition,
  output logic detect
);
  import stepper_ctrl_pkg::*;

  logic [OL_CNT_W-1:0] count, limit;

  // Window length chosen by the select field
  always_comb begin
    case (timeSelect)
      2'b00: limit = OL_CNT_W'(CYC0);
      2'b01: limit = OL_CNT_W'(CYC1);
      2'b10: limit = OL_CNT_W'(CYC2);
      default: limit = OL_CNT_W'(CYC3);
    endcase
  end

  // Condition must persist a whole window; fires once per episode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      detect <= 1'b0;
    end else begin
      detect <= 1'b0;
      if (!enable || !condition) begin
        count <= '0;
      end else if (count < limit) begin
        count <= count + OL_CNT_W'(1);
        detect <= (count == limit - OL_CNT_W'(1));
      end
    end
  end

endmodule : open_load_timer

// [src/stepper_ctrl_register_bank.sv]
// Step, fault-protection and stall control register bank with serial access
//
// Overview of operation
// - Register direction bit sets rotation sense
// - Writing step bit advances indexer once
// - Step bit clears itself after write
// - Direction source: pin at zero, register one
// - Step source: pin at zero, register one
// - Decode resolution field, full through 1/256
// - Fault clear empties latches, then self-clears
// - Lock code blocks writes except lock, clear
// - Unlocked: other lock codes change nothing
// - Unlock code reopens; resets unlocked
// - Open-load enable switches open-load detection
// - Overcurrent response: latched or auto-retry
// - Thermal shutdown response: latched or auto
// - Temperature warnings reach pin when enabled
// - Extended variant: timing and blanking bits
// - Stall learn starts, clears when done
// - Stall enable switches stall detection
// - Stall report gates stall onto pin
// - Open-load window 200/125/75/3 ms
`timescale 1ns/10ps
module stepper_ctrl_register_bank #(
  parameter bit EXTENDED_VARIANT = 1'b1,
  parameter int unsigned OL_CYC0 = stepper_ctrl_pkg::OL_TIME0_CYC,
  parameter int unsigned OL_CYC1 = stepper_ctrl_pkg::OL_TIME1_CYC,
  parameter int unsigned OL_CYC2 = stepper_ctrl_pkg::OL_TIME2_CYC,
  parameter int unsigned OL_CYC3 = stepper_ctrl_pkg::OL_TIME3_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdi,
  output logic sdo,
  output logic sdoEn,
  input wire logic stepPin,
  input wire logic dirPin,
  input wire logic overcurrentRaw,
  input wire logic overtempShutdownRaw,
  input wire logic overtempWarnRaw,
  input wire logic undertempWarnRaw,
  input wire logic openLoadRaw,
  input wire logic stallRaw,
  input wire logic stallLearnDone,
  output logic stepAdvance,
  output logic stepDirection,
  output stepper_ctrl_pkg::drv_cfg_t drvCfg,
  output logic faultClearPulse,
  output logic faultIndicatorPinOut,
  output logic faultIndicatorPinOe
);
  import stepper_ctrl_pkg::*;

  // Synchronised pin levels and their previous values
  logic [7:0] pinMeta, pinSync, pinPrev;
  logic stepPinLvl, dirPinLvl, ocpLvl, otsLvl, otwLvl, utwLvl, olLvl, stlLvl;
  logic stepPinRise, ocpRise, otsRise, stlRise;

  // Link side
  spi_req_t req;
  logic reqValid;
  logic [4:0] rdAddr;
  logic [7:0] rdData, statusByte;

  // Register fields
  logic dirBit, stepBit, dirSrc, stepSrc;
  logic [3:0] resolutionField;
  logic faultClearBit;
  logic [2:0] lockField;
  logic openLoadEnable, overcurrentResponseSelect;
  logic thermalShutdownResponseSelect, thermalWarningReport;
  logic [1:0] stallRsvd;
  logic stallLearnRequest, stallDetectEnable, stallReportEnable;
  logic [1:0] openLoadTimeSelect;
  logic slewBasedBlankingSelect;

  // Write strobes and state
  logic locked, wrAny, wrStep, wrFault, wrStall;
  logic olDetect;
  logic ocpFlt, otsFlt, olFlt, stallFlt, learnOk, warnActive, faultAny;

  // Outside pin levels except stallLearnDone pass two flops before any logic reads them
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinMeta <= 8'h00;
      pinSync <= 8'h00;
      pinPrev <= 8'h00;
    end else begin
      pinMeta <= {stepPin, dirPin, overcurrentRaw, overtempShutdownRaw,
                  overtempWarnRaw, undertempWarnRaw, openLoadRaw, stallRaw};
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  assign stepPinLvl = pinSync[7];
  assign dirPinLvl = pinSync[6];
  assign ocpLvl = pinSync[5];
  assign otsLvl = pinSync[4];
  assign otwLvl = pinSync[3];
  assign utwLvl = pinSync[2];
  assign olLvl = pinSync[1];
  assign stlLvl = pinSync[0];
  assign stepPinRise = pinSync[7] & ~pinPrev[7];
  assign ocpRise = pinSync[5] & ~pinPrev[5];
  assign otsRise = pinSync[4] & ~pinPrev[4];
  assign stlRise = pinSync[0] & ~pinPrev[0];

  // Serial register port
  spi_frame_link u_link (
    .ref_clk(ref_clk),
    .rst(rst),
    .sclk(sclk),
    .csN(csN),
    .sdi(sdi),
    .statusByte(statusByte),
    .rdData(rdData),
    .rdAddr(rdAddr),
    .sdo(sdo),
    .sdoEn(sdoEn),
    .req(req),
    .reqValid(reqValid)
  );

  // Write decode; the lock shuts out step and stall writes, fault writes are gated per field
  assign locked = (lockField == LOCK_CLOSE);
  assign wrAny = reqValid & req.write;
  assign wrStep = wrAny & (req.addr == ADDR_STEP_CTRL) & ~locked;
  assign wrFault = wrAny & (req.addr == ADDR_FAULT_CTRL);
  assign wrStall = wrAny & (req.addr == ADDR_STALL_CTRL) & ~locked;

  // Step, direction and resolution register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dirBit <= STEP_CTRL_RST[DIR_BIT];
      dirSrc <= STEP_CTRL_RST[DIR_SRC_BIT];
      stepSrc <= STEP_CTRL_RST[STEP_SRC_BIT];
      resolutionField <= STEP_CTRL_RST[RES_MSB:RES_LSB];
    end else if (wrStep) begin
      dirBit <= req.data[DIR_BIT];
      dirSrc <= req.data[DIR_SRC_BIT];
      stepSrc <= req.data[STEP_SRC_BIT];
      resolutionField <= req.data[RES_MSB:RES_LSB];
    end
  end

  // Step request lives a single cycle, so it can never read back as set
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stepBit <= STEP_CTRL_RST[STEP_BIT];
    end else begin
      stepBit <= wrStep & req.data[STEP_BIT];
    end
  end

  // Step and direction source selection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stepAdvance <= 1'b0;
      stepDirection <= 1'b0;
    end else begin
      stepAdvance <= stepSrc ? stepBit : stepPinRise;
      stepDirection <= dirSrc ? dirBit : dirPinLvl;
    end
  end

  // Lock field: each state only answers to the code that leaves it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lockField <= FAULT_CTRL_RST[LOCK_MSB:LOCK_LSB];
    end else if (wrFault) begin
      if (!locked && req.data[LOCK_MSB:LOCK_LSB] == LOCK_CLOSE) begin
        lockField <= LOCK_CLOSE;
      end else if (locked && req.data[LOCK_MSB:LOCK_LSB] == LOCK_OPEN) begin
        lockField <= LOCK_OPEN;
      end
    end
  end

  // Fault clear is honoured even while locked, then drops by itself
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      faultClearBit <= FAULT_CTRL_RST[FLT_CLR_BIT];
    end else begin
      faultClearBit <= wrFault & req.data[FLT_CLR_BIT];
    end
  end

  assign faultClearPulse = faultClearBit;

  // Protection mode bits, shut out while locked
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      openLoadEnable <= FAULT_CTRL_RST[OL_EN_BIT];
      overcurrentResponseSelect <= FAULT_CTRL_RST[OCP_SEL_BIT];
      thermalShutdownResponseSelect <= FAULT_CTRL_RST[OTSD_SEL_BIT];
      thermalWarningReport <= FAULT_CTRL_RST[THERMAL_WARNING_REPORT_BIT];
    end else if (wrFault && !locked) begin
      openLoadEnable <= req.data[OL_EN_BIT];
      overcurrentResponseSelect <= req.data[OCP_SEL_BIT];
      thermalShutdownResponseSelect <= req.data[OTSD_SEL_BIT];
      thermalWarningReport <= req.data[THERMAL_WARNING_REPORT_BIT];
    end
  end

  // Stall and open-load timing register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stallRsvd <= STALL_CTRL_RST[STL_RSVD_MSB:STL_RSVD_LSB];
      stallDetectEnable <= STALL_CTRL_RST[STL_EN_BIT];
      stallReportEnable <= STALL_CTRL_RST[STALL_REPORT_ENABLE_BIT];
      openLoadTimeSelect <= STALL_CTRL_RST[OPEN_LOAD_TIME_SELECT_MSB:OPEN_LOAD_TIME_SELECT_LSB];
      slewBasedBlankingSelect <= STALL_CTRL_RST[BLANK_BIT];
    end else if (wrStall) begin
      stallRsvd <= req.data[STL_RSVD_MSB:STL_RSVD_LSB];
      stallDetectEnable <= req.data[STL_EN_BIT];
      stallReportEnable <= req.data[STALL_REPORT_ENABLE_BIT];
      // Base variant keeps these bits at zero
      if (EXTENDED_VARIANT) begin
        openLoadTimeSelect <= req.data[OPEN_LOAD_TIME_SELECT_MSB:OPEN_LOAD_TIME_SELECT_LSB];
        slewBasedBlankingSelect <= req.data[BLANK_BIT];
      end
    end
  end

  // Learn request holds until learning reports done; a new request wins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stallLearnRequest <= STALL_CTRL_RST[STALL_LEARN_REQUEST_BIT];
    end else if (wrStall && req.data[STALL_LEARN_REQUEST_BIT]) begin
      stallLearnRequest <= 1'b1;
    end else if (stallLearnDone) begin
      stallLearnRequest <= 1'b0;
    end
  end

  // Learn success flag, dropped when a new learn starts
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      learnOk <= 1'b0;
    end else if (stallLearnDone && stallLearnRequest) begin
      learnOk <= 1'b1;
    end else if (wrStall && req.data[STALL_LEARN_REQUEST_BIT]) begin
      learnOk <= 1'b0;
    end
  end

  // Open-load qualification window
  open_load_timer #(
    .CYC0(OL_CYC0),
    .CYC1(OL_CYC1),
    .CYC2(OL_CYC2),
    .CYC3(OL_CYC3)
  ) u_ol_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(openLoadEnable),
    .timeSelect(openLoadTimeSelect),
    .condition(olLvl),
    .detect(olDetect)
  );

  // Overcurrent: latched until cleared, or follows the condition on retry
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ocpFlt <= 1'b0;
    end else if (overcurrentResponseSelect) begin
      ocpFlt <= ocpLvl;
    end else if (ocpRise) begin
      ocpFlt <= 1'b1;
    end else if (faultClearBit) begin
      ocpFlt <= 1'b0;
    end
  end

  // Thermal shutdown: latched or self-recovering
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      otsFlt <= 1'b0;
    end else if (thermalShutdownResponseSelect) begin
      otsFlt <= otsLvl;
    end else if (otsRise) begin
      otsFlt <= 1'b1;
    end else if (faultClearBit) begin
      otsFlt <= 1'b0;
    end
  end

  // Open-load and stall latches; a new event beats a same-cycle clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      olFlt <= 1'b0;
      stallFlt <= 1'b0;
    end else begin
      if (olDetect) begin
        olFlt <= 1'b1;
      end else if (faultClearBit || !openLoadEnable) begin
        olFlt <= 1'b0;
      end
      if (stlRise && stallDetectEnable) begin
        stallFlt <= 1'b1;
      end else if (faultClearBit) begin
        stallFlt <= 1'b0;
      end
    end
  end

  // Fault pin: open drain, pulled low while any reported fault stands
  assign warnActive = thermalWarningReport & (otwLvl | utwLvl);
  assign faultAny = ocpFlt | otsFlt | olFlt
                    | (stallReportEnable & stallFlt) | warnActive;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      faultIndicatorPinOe <= 1'b0;
    end else begin
      faultIndicatorPinOe <= faultAny;
    end
  end

  assign faultIndicatorPinOut = 1'b0;

  // Configuration to the indexer and protection logic
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      drvCfg <= '0;
    end else begin
      // Reserved codes clamp to the finest step rather than misbehave
      if (resolutionField > RES_LAST) begin
        drvCfg.ustepLog2 <= RES_LAST - RES_OFFSET;
      end else if (resolutionField > RES_HALF_NC) begin
        drvCfg.ustepLog2 <= resolutionField - RES_OFFSET;
      end else if (resolutionField == RES_HALF_NC) begin
        drvCfg.ustepLog2 <= 4'h1;
      end else begin
        drvCfg.ustepLog2 <= 4'h0;
      end
      drvCfg.fullStepReduced <= (resolutionField == RES_FULL_71);
      drvCfg.nonCircularHalf <= (resolutionField == RES_HALF_NC);
      drvCfg.openLoadEnable <= openLoadEnable;
      drvCfg.overcurrentResponseSelect <= overcurrentResponseSelect;
      drvCfg.thermalShutdownResponseSelect <= thermalShutdownResponseSelect;
      drvCfg.stallDetectEnable <= stallDetectEnable;
      drvCfg.stallLearnRequest <= stallLearnRequest;
      drvCfg.stallReportEnable <= stallReportEnable;
      drvCfg.openLoadTimeSelect <= openLoadTimeSelect;
      drvCfg.slewBasedBlankingSelect <= slewBasedBlankingSelect;
    end
  end

  // Status byte leads every reply frame
  assign statusByte = {STATUS_HEAD, faultAny, ocpFlt, otsFlt, olFlt,
                       stallFlt, learnOk};

  // Read mux; one-shot bits always read zero, unmapped reads zero
  always_comb begin
    case (rdAddr)
      ADDR_STEP_CTRL: begin
        rdData = {dirBit, 1'b0, dirSrc, stepSrc, resolutionField};
      end
      ADDR_FAULT_CTRL: begin
        rdData = {1'b0, lockField, openLoadEnable,
                  overcurrentResponseSelect,
                  thermalShutdownResponseSelect,
                  thermalWarningReport};
      end
      ADDR_STALL_CTRL: begin
        rdData = {stallRsvd, stallLearnRequest, stallDetectEnable,
                  stallReportEnable, openLoadTimeSelect,
                  slewBasedBlankingSelect};
      end
      default: rdData = 8'h00;
    endcase
  end

endmodule : stepper_ctrl_register_bank

// [dv/stepper_ctrl_register_bank_properties.sv]
// Port-level assertions of the stepper control register bank
`timescale 1ns/10ps
module stepper_ctrl_register_bank_properties (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic stepAdvance,
  input wire logic faultClearPulse,
  input wire logic stallLearnDone,
  input wire logic faultIndicatorPinOut,
  input wire stepper_ctrl_pkg::drv_cfg_t drvCfg
);
  import stepper_ctrl_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Single-cycle pulses, so one write never acts twice
  a_step_single: assert property (stepAdvance |=> !stepAdvance)
    else $error("step pulse longer than one cycle");
  a_clear_single: assert property (faultClearPulse |=> !faultClearPulse)
    else $error("fault clear pulse longer than one cycle");
  // Resolution decode stays consistent
  a_half_decode: assert property (drvCfg.nonCircularHalf |->
    drvCfg.ustepLog2 == 4'h1 && !drvCfg.fullStepReduced)
    else $error("non-circular half step decoded wrongly");
  a_full_decode: assert property (drvCfg.fullStepReduced |->
    drvCfg.ustepLog2 == 4'h0)
    else $error("reduced full step decoded wrongly");
  a_res_range: assert property (drvCfg.ustepLog2 <= 4'h8)
    else $error("resolution beyond finest step");
  // Open drain: the pin is only ever pulled low
  a_pin_drain: assert property (!faultIndicatorPinOut)
    else $error("fault pin driven high");
  a_learn_done: assert property (drvCfg.stallLearnRequest &&
    stallLearnDone |-> ##2 !drvCfg.stallLearnRequest)
    else $error("stall learn request not cleared");
  a_report_reset: assert property ($fell(rst) |=>
    drvCfg.stallReportEnable)
    else $error("stall report not set after reset");
endmodule : stepper_ctrl_register_bank_properties

// [dv/spi_host_model.sv]
// Serial host model: 16-bit frames, clock idle low
`timescale 1ns/10ps
module spi_host_model (
  output logic sclk,
  output logic csN,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    sdi = 1'b0;
  end
  // Drive on rising, device samples on falling; 125 ns period
  task automatic xfer(input logic [15:0] f, output logic [7:0] r);
    csN = 1'b0;
    #125;
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b1;
      sdi = f[i];
      #62.5;
      sclk = 1'b0;
      if (i < 8) r[i] = sdo;
      #62.5;
    end
    csN = 1'b1;
    // Released line flips so a stale bit is never trusted
    sdi = ~sdi;
    #500;
  endtask : xfer
endmodule : spi_host_model

// [dv/tb_stepper_ctrl_register_bank.sv]
// Testbench of the stepper control register bank
`timescale 1ns/10ps
module tb_stepper_ctrl_register_bank;
  import stepper_ctrl_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic stepPin = 1'b0, dirPin = 1'b0, ocRaw = 1'b0, warnRaw = 1'b0;
  logic learnDone = 1'b0, otsRaw = 1'b0, utRaw = 1'b0, olRaw = 1'b0;
  logic stallRaw = 1'b0;
  logic sclk, csN, sdi, sdo, sdoEn, stepAdvance, stepDirection;
  logic faultClearPulse, pinOut, pinOe;
  logic [7:0] rdv;
  drv_cfg_t drvCfg;
  int n_errors = 0, comparisons = 0, nSteps = 0, nClears = 0;
  always #5 ref_clk = ~ref_clk;
  // Pulse counters
  always @(posedge ref_clk) begin
    nSteps += stepAdvance;
    nClears += faultClearPulse;
  end
  // Short open-load windows keep the run brief
  stepper_ctrl_register_bank #(.OL_CYC0(40), .OL_CYC1(25), .OL_CYC2(15),
    .OL_CYC3(5)) u_dut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk),
    .csN(csN), .sdi(sdi), .sdo(sdo), .sdoEn(sdoEn), .stepPin(stepPin),
    .dirPin(dirPin), .overcurrentRaw(ocRaw), .overtempShutdownRaw(otsRaw),
    .overtempWarnRaw(warnRaw), .undertempWarnRaw(utRaw),
    .openLoadRaw(olRaw), .stallRaw(stallRaw), .stallLearnDone(learnDone),
    .stepAdvance(stepAdvance), .stepDirection(stepDirection),
    .drvCfg(drvCfg), .faultClearPulse(faultClearPulse),
    .faultIndicatorPinOut(pinOut), .faultIndicatorPinOe(pinOe));
  spi_host_model u_host (.sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    cyc(1);
    u_host.xfer({2'b00, a, 1'b0, d}, rdv);
    cyc(1);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    cyc(1);
    u_host.xfer({2'b01, a, 9'h000}, rdv);
    check(rdv, e);
  endtask : rd
  task automatic t_reset;
    check({7'h0, sdoEn}, 8'h00);
    rd(ADDR_STEP_CTRL, 8'h00);
    rd(ADDR_FAULT_CTRL, 8'h30);
    rd(ADDR_STALL_CTRL, 8'h08);
    rd(5'h0c, 8'h00);
  endtask : t_reset
  task automatic t_res;
    logic [5:0] e;
    for (int c = 0; c <= 10; c++) begin
      wr(ADDR_STEP_CTRL, 8'(c));
      e = c < 2 ? {4'h0, c == 1, 1'b0} : {4'(c - 2 + (c == 2)), 1'b0, c == 2};
      check({2'b00, drvCfg.ustepLog2, drvCfg.fullStepReduced,
        drvCfg.nonCircularHalf}, {2'b00, e});
    end
  endtask : t_res
  task automatic t_step;
    int s;
    s = nSteps;
    wr(ADDR_STEP_CTRL, 8'h50);
    check(8'(nSteps - s), 8'h01);
    rd(ADDR_STEP_CTRL, 8'h10);
    wr(ADDR_STEP_CTRL, 8'ha0);
    check({7'h0, stepDirection}, 8'h01);
    wr(ADDR_STEP_CTRL, 8'hc0);
    check({7'h0, stepDirection}, 8'h00);
    dirPin = 1'b1;
    cyc(4);
    check({7'h0, stepDirection}, 8'h01);
    stepPin = 1'b1;
    cyc(8);
    stepPin = 1'b0;
    cyc(8);
    check(8'(nSteps - s), 8'h02);
  endtask : t_step
  task automatic t_lock;
    int c;
    wr(ADDR_FAULT_CTRL, 8'h10);
    wr(ADDR_STEP_CTRL, 8'h03);
    rd(ADDR_STEP_CTRL, 8'h03);
    wr(ADDR_FAULT_CTRL, 8'h60);
    wr(ADDR_STEP_CTRL, 8'h05);
    wr(ADDR_STALL_CTRL, 8'h00);
    rd(ADDR_STEP_CTRL, 8'h03);
    rd(ADDR_STALL_CTRL, 8'h08);
    c = nClears;
    wr(ADDR_FAULT_CTRL, 8'h50);
    wr(ADDR_FAULT_CTRL, 8'he0);
    check(8'(nClears - c), 8'h01);
    wr(ADDR_STEP_CTRL, 8'h05);
    rd(ADDR_STEP_CTRL, 8'h03);
    wr(ADDR_FAULT_CTRL, 8'h30);
    wr(ADDR_STEP_CTRL, 8'h05);
    rd(ADDR_STEP_CTRL, 8'h05);
  endtask : t_lock
  task automatic t_fault;
    wr(ADDR_FAULT_CTRL, 8'h31);
    {warnRaw, utRaw} = 2'b01;
    cyc(6);
    check({7'h0, pinOe}, 8'h01);
    {warnRaw, utRaw} = 2'b10;
    cyc(6);
    check({7'h0, pinOe}, 8'h01);
    wr(ADDR_FAULT_CTRL, 8'h30);
    check({7'h0, pinOe}, 8'h00);
    warnRaw = 1'b0;
    ocRaw = 1'b1;
    cyc(6);
    ocRaw = 1'b0;
    cyc(6);
    check({7'h0, pinOe}, 8'h01);
    wr(ADDR_FAULT_CTRL, 8'hb0);
    check({7'h0, pinOe}, 8'h00);
    otsRaw = 1'b1;
    cyc(6);
    otsRaw = 1'b0;
    cyc(6);
    check({7'h0, pinOe}, 8'h01);
    wr(ADDR_FAULT_CTRL, 8'h3e);
    check({5'h0, drvCfg.openLoadEnable, drvCfg.overcurrentResponseSelect,
      drvCfg.thermalShutdownResponseSelect}, 8'h07);
    {ocRaw, otsRaw} = 2'b11;
    cyc(6);
    {ocRaw, otsRaw} = 2'b00;
    cyc(6);
    check({7'h0, pinOe}, 8'h00);
  endtask : t_fault
  task automatic t_stall;
    wr(ADDR_STALL_CTRL, 8'h3f);
    check({2'b00, drvCfg.stallLearnRequest, drvCfg.stallDetectEnable,
      drvCfg.stallReportEnable, drvCfg.openLoadTimeSelect,
      drvCfg.slewBasedBlankingSelect}, 8'h3f);
    rd(ADDR_STALL_CTRL, 8'h3f);
    cyc(1);
    learnDone = 1'b1;
    cyc(1);
    learnDone = 1'b0;
    rd(ADDR_STALL_CTRL, 8'h1f);
    stallRaw = 1'b1;
    cyc(6);
    check({7'h0, pinOe}, 8'h01);
    wr(ADDR_STALL_CTRL, 8'h17);
    check({7'h0, pinOe}, 8'h00);
    olRaw = 1'b1;
    cyc(12);
    check({7'h0, pinOe}, 8'h01);
  endtask : t_stall
  task automatic stop_test;
    if (n_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    cyc(4);
    t_reset();
    t_res();
    t_step();
    t_lock();
    t_fault();
    t_stall();
    stop_test();
  end
  // Watchdog, well beyond the 42 frames of the run
  initial begin
    #400000;
    n_errors++;
    stop_test();
  end
endmodule : tb_stepper_ctrl_register_bank
bind stepper_ctrl_register_bank stepper_ctrl_register_bank_properties
  u_props (.ref_clk(ref_clk), .rst(rst), .stepAdvance(stepAdvance),
  .faultClearPulse(faultClearPulse), .stallLearnDone(stallLearnDone),
  .faultIndicatorPinOut(faultIndicatorPinOut), .drvCfg(drvCfg));
